// file: common/dgp_pkg.sv
// constants, field layout and state type of the dual gpio port block
// assumes a 32-bit apb slave with word-aligned registers

package dgp_pkg;

   // port geometry
   localparam int PORT_W = 8;
   localparam int CHSEL_W = 5;
   localparam int APB_DW = 32;
   localparam int APB_AW = 12;

   // register indices as printed; byte address is four times the index
   localparam logic [APB_AW-1:0] IDX_A_DATA = 12'h000;
   localparam logic [APB_AW-1:0] IDX_B_DATA = 12'h001;
   localparam logic [APB_AW-1:0] IDX_A_DIR = 12'h004;
   localparam logic [APB_AW-1:0] IDX_B_DIR = 12'h005;
   localparam logic [APB_AW-1:0] ADDR_A_DATA = IDX_A_DATA << 2;
   localparam logic [APB_AW-1:0] ADDR_B_DATA = IDX_B_DATA << 2;
   localparam logic [APB_AW-1:0] ADDR_A_DIR = IDX_A_DIR << 2;
   localparam logic [APB_AW-1:0] ADDR_B_DIR = IDX_B_DIR << 2;

   // reset value of both direction registers: all pins inputs
   localparam logic [PORT_W-1:0] DIR_RESET = 8'h00;
   localparam logic [PORT_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [APB_DW-1:0] WORD_ZERO = 32'h0000_0000;

   // converter channel number of the second port's bit 0
   localparam logic [CHSEL_W-1:0] CHAN_BASE_B = 5'h00;

   // byte lane that carries the 8-bit registers
   localparam int LANE_LOW = 0;

   // whole register state of the block
   typedef struct packed
   {
      logic [PORT_W-1:0] latchA;
      logic [PORT_W-1:0] latchB;
      logic [PORT_W-1:0] dirA;
      logic [PORT_W-1:0] dirB;
      logic [APB_DW-1:0] rdata;
   } dgp_state_t;

endpackage : dgp_pkg

// file: hw/dgp_pin_mux.sv
// per-port pad steering and read-back selection
// assumes pad inputs and claim bits are synchronous to the system clock

`timescale 1ns/1ns

module dgp_pin_mux
   import dgp_pkg::*;
#(
   parameter int WIDTH = PORT_W
)
(
   input wire logic [WIDTH-1:0] latchVal,
   input wire logic [WIDTH-1:0] dirVal,
   input wire logic [WIDTH-1:0] claim,
   input wire logic [WIDTH-1:0] padIn,
   output logic [WIDTH-1:0] padOe,
   output logic [WIDTH-1:0] padOut,
   output logic [WIDTH-1:0] readVal
);

   genvar i;

   // one slice per pin; a claimed pin is never driven, whatever its direction bit
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_pin
         assign padOe[i] = dirVal[i] & ~claim[i];
         assign padOut[i] = latchVal[i]; // latch drives only when enabled
         // output pin reads its latch, claimed input reads zero, else the pad level
         assign readVal[i] = dirVal[i] ? latchVal[i] : (~claim[i] & padIn[i]);
      end
   endgenerate

endmodule : dgp_pin_mux

// file: hw/dgp_port.sv
// two 8-bit bidirectional gpio ports behind an apb slave
// assumes pads resolve the wire from padXOe/padXOut and return padXIn synchronously
// assumes the converter presents its channel select and an enable each cycle
//
// The APB interface to the registers is this design's own decision.

`timescale 1ns/1ns

module dgp_port
   import dgp_pkg::*;
#(
   parameter int WIDTH = PORT_W
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [APB_DW-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [WIDTH-1:0] padAIn,
   output logic [WIDTH-1:0] padAOut,
   output logic [WIDTH-1:0] padAOe,
   input wire logic [WIDTH-1:0] padBIn,
   output logic [WIDTH-1:0] padBOut,
   output logic [WIDTH-1:0] padBOe,
   input wire logic convEnable,
   input wire logic [CHSEL_W-1:0] convChanSel
);

   dgp_state_t state_reg;
   dgp_state_t state_next;
   logic [WIDTH-1:0] claimB;
   logic [WIDTH-1:0] readA;
   logic [WIDTH-1:0] readB;
   logic setupPhase;
   logic accessPhase;
   logic hitAData;
   logic hitBData;
   logic hitADir;
   logic hitBDir;
   logic mapped;
   logic doWrite;
   logic laneLow;

   genvar c;

   // converter claim per pin: the select names this pin's channel
   generate
      for (c = 0; c < WIDTH; c++)
      begin : g_claim
         assign claimB[c] = convEnable && (convChanSel == CHSEL_W'(CHAN_BASE_B + c));
      end
   endgenerate

   // first port has no converter sharing, so its claim is tied off
   dgp_pin_mux #(
      .WIDTH(WIDTH)
   ) u_mux_a (
      .latchVal(state_reg.latchA),
      .dirVal(state_reg.dirA),
      .claim({WIDTH{1'b0}}),
      .padIn(padAIn),
      .padOe(padAOe),
      .padOut(padAOut),
      .readVal(readA)
   );

   // second port: claimed pins stay undriven and read zero as inputs
   dgp_pin_mux #(
      .WIDTH(WIDTH)
   ) u_mux_b (
      .latchVal(state_reg.latchB),
      .dirVal(state_reg.dirB),
      .claim(claimB),
      .padIn(padBIn),
      .padOe(padBOe),
      .padOut(padBOut),
      .readVal(readB)
   );

   // address decode; a misaligned or unknown address is an error answer
   assign hitAData = (paddr == ADDR_A_DATA);
   assign hitBData = (paddr == ADDR_B_DATA);
   assign hitADir = (paddr == ADDR_A_DIR);
   assign hitBDir = (paddr == ADDR_B_DIR);
   assign mapped = hitAData | hitBData | hitADir | hitBDir;
   assign setupPhase = psel & ~penable;
   assign accessPhase = psel & penable;
   assign laneLow = pstrb[LANE_LOW];
   assign doWrite = accessPhase & pwrite & mapped & laneLow;

   // read data is captured in setup, so every access finishes in one access cycle
   assign pready = accessPhase;
   assign pslverr = accessPhase & ~mapped;
   assign prdata = state_reg.rdata;

   // next-state logic for latches, directions and read data
   always_comb
   begin
      state_next = state_reg;
      // writes land whatever the direction bit holds; the pin only follows when enabled
      if (doWrite && hitAData)
      begin
         state_next.latchA = pwdata[PORT_W-1:0];
      end
      if (doWrite && hitBData)
      begin
         state_next.latchB = pwdata[PORT_W-1:0];
      end
      if (doWrite && hitADir)
      begin
         state_next.dirA = pwdata[PORT_W-1:0];
      end
      if (doWrite && hitBDir)
      begin
         state_next.dirB = pwdata[PORT_W-1:0];
      end
      // pad levels are sampled in the setup cycle; unmapped reads give zero
      if (setupPhase && !pwrite)
      begin
         state_next.rdata = WORD_ZERO;
         if (hitAData)
         begin
            state_next.rdata[PORT_W-1:0] = readA;
         end
         else if (hitBData)
         begin
            state_next.rdata[PORT_W-1:0] = readB;
         end
         else if (hitADir)
         begin
            state_next.rdata[PORT_W-1:0] = state_reg.dirA;
         end
         else if (hitBDir)
         begin
            state_next.rdata[PORT_W-1:0] = state_reg.dirB;
         end
      end
   end

   // latches carry no reset so their content survives it; directions clear
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg.dirA <= DIR_RESET;
         state_reg.dirB <= DIR_RESET;
         state_reg.rdata <= WORD_ZERO;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // checks on the block's own outputs and state

   property p_dir_cleared(logic [WIDTH-1:0] dirv);
      @(posedge clock) disable iff (!rst_n)
         !$past(rst_n) |-> (dirv == DIR_RESET);
   endproperty

   a_dir_a_reset: assert property (p_dir_cleared(state_reg.dirA))
      else $error("first port direction not clear after reset");

   a_dir_b_reset: assert property (p_dir_cleared(state_reg.dirB))
      else $error("second port direction not clear after reset");

   a_oe_a_follows: assert property (
      @(posedge clock) disable iff (!rst_n)
         padAOe == state_reg.dirA)
      else $error("first port enable differs from direction");

   a_oe_b_claim: assert property (
      @(posedge clock) disable iff (!rst_n)
         (padBOe & claimB) == BYTE_ZERO)
      else $error("claimed second port pin is driven");

   a_oe_b_free: assert property (
      @(posedge clock) disable iff (!rst_n)
         (padBOe & ~claimB) == (state_reg.dirB & ~claimB))
      else $error("unclaimed second port enable differs from direction");

   // the converter owns at most one channel, and none while it is off
   a_claim_single: assert property (
      @(posedge clock) disable iff (!rst_n)
         $onehot0(claimB))
      else $error("more than one second port pin claimed");

   a_claim_off: assert property (
      @(posedge clock) disable iff (!rst_n)
         !convEnable |-> (claimB == BYTE_ZERO))
      else $error("pin claimed while converter is off");

   a_latch_write: assert property (
      @(posedge clock) disable iff (!rst_n)
         (doWrite && hitAData) |=> (state_reg.latchA == $past(pwdata[PORT_W-1:0])))
      else $error("first port latch missed a write");

   a_latch_b_write: assert property (
      @(posedge clock) disable iff (!rst_n)
         (doWrite && hitBData) |=> (state_reg.latchB == $past(pwdata[PORT_W-1:0])))
      else $error("second port latch missed a write");

   a_read_a_mix: assert property (
      @(posedge clock) disable iff (!rst_n)
         (setupPhase && !pwrite && hitAData) |=>
            (prdata[PORT_W-1:0] == (($past(state_reg.dirA) & $past(state_reg.latchA))
            | (~$past(state_reg.dirA) & $past(padAIn)))))
      else $error("first port read-back wrong");

   a_read_b_zero: assert property (
      @(posedge clock) disable iff (!rst_n)
         (setupPhase && !pwrite && hitBData) |=>
            ((prdata[PORT_W-1:0] & $past(claimB) & ~$past(state_reg.dirB)) == BYTE_ZERO))
      else $error("claimed input pin did not read zero");

   a_read_b_latch: assert property (
      @(posedge clock) disable iff (!rst_n)
         (setupPhase && !pwrite && hitBData) |=>
            ((prdata[PORT_W-1:0] & $past(state_reg.dirB))
            == ($past(state_reg.latchB) & $past(state_reg.dirB))))
      else $error("second port output pin did not read latch");

   // masks keep latch bits out, so an unwritten latch cannot make this fail
   a_read_b_pad: assert property (
      @(posedge clock) disable iff (!rst_n)
         (setupPhase && !pwrite && hitBData) |=>
            ((prdata[PORT_W-1:0] & ~$past(state_reg.dirB) & ~$past(claimB))
            == ($past(padBIn) & ~$past(state_reg.dirB) & ~$past(claimB))))
      else $error("free second port input pin did not read pad");

   // a read of the second port's direction returns the register as held in the setup cycle
   a_dir_roundtrip: assert property (
      @(posedge clock) disable iff (!rst_n)
         (setupPhase && !pwrite && hitBDir)
            |=> (prdata[PORT_W-1:0] == $past(state_reg.dirB)))
      else $error("second port direction did not read back");

   a_dir_a_read: assert property (
      @(posedge clock) disable iff (!rst_n)
         (setupPhase && !pwrite && hitADir)
            |=> (prdata[PORT_W-1:0] == $past(state_reg.dirA)))
      else $error("first port direction did not read back");

   a_dir_a_write: assert property (
      @(posedge clock) disable iff (!rst_n)
         (doWrite && hitADir) |=> (state_reg.dirA == $past(pwdata[PORT_W-1:0])))
      else $error("first port direction missed a write");

   a_dir_b_write: assert property (
      @(posedge clock) disable iff (!rst_n)
         (doWrite && hitBDir) |=> (state_reg.dirB == $past(pwdata[PORT_W-1:0])))
      else $error("second port direction missed a write");

   a_ready_err: assert property (
      @(posedge clock) disable iff (!rst_n)
         accessPhase |-> (pready && (pslverr == !mapped)))
      else $error("apb answer wrong");

   // an error answer must not disturb the pins' direction
   a_err_write_kept: assert property (
      @(posedge clock) disable iff (!rst_n)
         (accessPhase && pwrite && !mapped) |=>
            ($stable(state_reg.dirA) && $stable(state_reg.dirB)))
      else $error("unmapped write changed a direction register");

   c_write_a: cover property (
      @(posedge clock) disable iff (!rst_n) doWrite && hitAData);

   c_read_b_claim: cover property (
      @(posedge clock) disable iff (!rst_n)
         setupPhase && !pwrite && hitBData && (claimB != BYTE_ZERO));

   c_unmapped: cover property (
      @(posedge clock) disable iff (!rst_n) pslverr);

   c_claim_output: cover property (
      @(posedge clock) disable iff (!rst_n)
         setupPhase && !pwrite && hitBData && ((claimB & state_reg.dirB) != BYTE_ZERO));

endmodule : dgp_port

// file: sim/dgp_pad_model.sv
// pad ring and converter channel selector facing the dual gpio port
// assumes the bench sets the external pin levels and the claim request

`timescale 1ns/1ns

module dgp_pad_model
   import dgp_pkg::*;
(
   input wire logic [PORT_W-1:0] padAOut,
   input wire logic [PORT_W-1:0] padAOe,
   input wire logic [PORT_W-1:0] padBOut,
   input wire logic [PORT_W-1:0] padBOe,
   input wire logic [PORT_W-1:0] extA,
   input wire logic [PORT_W-1:0] extB,
   input wire logic claimOn,
   input wire logic [CHSEL_W-1:0] claimSel,
   output logic [PORT_W-1:0] padAIn,
   output logic [PORT_W-1:0] padBIn,
   output logic convEnable,
   output logic [CHSEL_W-1:0] convChanSel
);
   // a driven pin shows the block's value, an undriven one the outside level
   assign padAIn = (padAOe & padAOut) | (~padAOe & extA);
   assign padBIn = (padBOe & padBOut) | (~padBOe & extB);
   // selector claims one pin while the converter is on
   assign convEnable = claimOn;
   assign convChanSel = claimSel;
endmodule : dgp_pad_model

// file: sim/dual_gpio_port_adc_shared_test.sv
// self-checking bench for the dual gpio port block
// assumes dgp_pkg and the pad model are compiled first

`timescale 1ns/1ns

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
   $display("mismatch %s exp %h got %h", nm, exp, got); end end

module dual_gpio_port_adc_shared_test
   import dgp_pkg::*;
;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, convEnable, claimOn;
   logic [APB_AW-1:0] paddr;
   logic [APB_DW-1:0] pwdata, prdata, rd;
   logic [PORT_W-1:0] padAIn, padAOut, padAOe, padBIn, padBOut, padBOe, extA, extB;
   logic [CHSEL_W-1:0] convChanSel, claimSel;
   int fails, n_checks;

   dgp_port i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .padAIn(padAIn), .padAOut(padAOut),
      .padAOe(padAOe), .padBIn(padBIn), .padBOut(padBOut), .padBOe(padBOe),
      .convEnable(convEnable), .convChanSel(convChanSel));

   dgp_pad_model i_pads (.padAOut(padAOut), .padAOe(padAOe), .padBOut(padBOut),
      .padBOe(padBOe), .extA(extA), .extB(extB), .claimOn(claimOn), .claimSel(claimSel),
      .padAIn(padAIn), .padBIn(padBIn), .convEnable(convEnable), .convChanSel(convChanSel));

   // one apb transfer; leaves at the falling edge so pads have settled
   task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
      int n;
      begin
         n = 0;
         @(posedge clock);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         do
         begin
            @(posedge clock);
            n++;
         end
         while (pready !== 1'b1 && n < 20);
         if (pready !== 1'b1)
         begin
            fails++;
            close_out();
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(negedge clock);
      end
   endtask : apb

   task automatic t_porta;
      begin
         @(posedge clock);
         extA <= 8'h3C;
         apb(1'b1, ADDR_A_DATA, 32'h0000_00A5);
         `CHK("oeA", 8'h00, padAOe)
         apb(1'b0, ADDR_A_DATA, WORD_ZERO);
         `CHK("rdA", 32'h0000_003C, rd)
         apb(1'b1, ADDR_A_DIR, 32'h0000_00F0);
         `CHK("oeA", 8'hF0, padAOe)
         `CHK("outA", 8'hA5, padAOut)
         apb(1'b0, ADDR_A_DIR, WORD_ZERO);
         `CHK("dirA", 32'h0000_00F0, rd)
         apb(1'b0, ADDR_A_DATA, WORD_ZERO);
         `CHK("rdA", 32'h0000_00AC, rd)
         $display("test porta done");
      end
   endtask : t_porta

   // walk the claim over every pin, then converter off
   task automatic t_portb;
      logic [PORT_W-1:0] m;
      begin
         @(posedge clock);
         extB <= 8'hC3;
         apb(1'b1, ADDR_B_DATA, 32'h0000_005A);
         apb(1'b1, ADDR_B_DIR, 32'h0000_000F);
         `CHK("outB", 8'h5A, padBOut)
         for (int i = 0; i < 9; i++)
         begin
            @(posedge clock);
            claimOn <= (i < 8);
            claimSel <= i[4:0];
            m = (i < 8) ? (8'h01 << i) : 8'h00;
            apb(1'b0, ADDR_B_DATA, WORD_ZERO);
            `CHK("oeB", 8'h0F & ~m, padBOe)
            `CHK("rdB", ({24'h000000, 8'h0A | (8'hC0 & ~m)}), rd)
         end
         $display("test portb done");
      end
   endtask : t_portb

   // reset mid-run: directions clear, latches keep their contents
   task automatic t_reset;
      begin
         @(posedge clock);
         rst_n <= 1'b0;
         repeat (2) @(posedge clock);
         rst_n <= 1'b1;
         @(negedge clock);
         `CHK("oeA", 8'h00, padAOe)
         `CHK("oeB", 8'h00, padBOe)
         `CHK("outA", 8'hA5, padAOut)
         `CHK("outB", 8'h5A, padBOut)
         apb(1'b0, ADDR_B_DIR, WORD_ZERO);
         `CHK("dirB", WORD_ZERO, rd)
         apb(1'b0, 12'h020, WORD_ZERO);
         `CHK("errU", 1'b1, err)
         `CHK("rdU", WORD_ZERO, rd)
         // a write to a hole answers with an error and leaves the pins as inputs
         apb(1'b1, 12'h020, 32'h0000_00FF);
         `CHK("errW", 1'b1, err)
         `CHK("oeA", 8'h00, padAOe)
         `CHK("oeB", 8'h00, padBOe)
         $display("test reset done");
      end
   endtask : t_reset

   task close_out;
      begin
         $display("checks %0d mismatches %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask : close_out

   // free-running 10 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // reset, then the scenarios in turn
   initial
   begin
      {rst_n, psel, penable, pwrite, claimOn} = 5'h00;
      paddr = 12'h000;
      pwdata = WORD_ZERO;
      {extA, extB} = 16'h0000;
      claimSel = 5'h00;
      fails = 0;
      n_checks = 0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      t_porta();
      t_portb();
      t_reset();
      close_out();
   end
endmodule : dual_gpio_port_adc_shared_test
